// >>> design/vpg_pkg.sv
// Shared constants of the video pattern generator and self-test checker
package vpg_pkg;

   // -----------------------------------------------------------------
   // Register indices; byte address on the bus is four times the index
   // -----------------------------------------------------------------
   localparam logic [7:0] IX_CTL = 8'h64;   // Enable and fixed pattern
   localparam logic [7:0] IX_CFG = 8'h65;   // Pattern configuration
   localparam logic [7:0] IX_IA  = 8'h66;   // Indirect address
   localparam logic [7:0] IX_ID  = 8'h67;   // Indirect data
   localparam logic [7:0] IX_DBG = 8'h68;   // Self-test control
   localparam logic [7:0] IX_RES = 8'h69;   // Self-test result
   localparam int         PADDR_W = 12;

   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int CTL_EN     = 0;
   localparam int CTL_SEL    = 4;
   localparam int CFG_ASCRL  = 0;
   localparam int CFG_INV    = 1;
   localparam int CFG_TSEL   = 2;
   localparam int CFG_EXTCLK = 3;
   localparam int CFG_18B    = 4;
   localparam int DBG_BIST   = 3;
   localparam int RES_ERR    = 7;
   localparam logic [7:0] CTL_RST = 8'h10;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] CFG_MSK = 8'h1f;
   localparam logic [7:0] IA_RST  = 8'h00;
   localparam logic [7:0] DBG_RST = 8'h00;

   // -----------------------------------------------------------------
   // Indirect register map
   // -----------------------------------------------------------------
   localparam int         IND_DEPTH = 32;
   localparam logic [7:0] IND_TOTH  = 8'h00;   // Lo byte, hi nibble next
   localparam logic [7:0] IND_TOTV  = 8'h02;
   localparam logic [7:0] IND_ACTH  = 8'h04;
   localparam logic [7:0] IND_ACTV  = 8'h06;
   localparam logic [7:0] IND_HSW   = 8'h08;
   localparam logic [7:0] IND_VSW   = 8'h09;
   localparam logic [7:0] IND_HBP   = 8'h0a;
   localparam logic [7:0] IND_VBP   = 8'h0b;
   localparam logic [7:0] IND_SYNC  = 8'h0c;   // Bit 0 hsync low, 1 vsync low
   localparam logic [7:0] IND_FT    = 8'h0d;   // Frames per scrolled pattern
   localparam logic [7:0] IND_RED   = 8'h0e;
   localparam logic [7:0] IND_GRN   = 8'h0f;
   localparam logic [7:0] IND_BLU   = 8'h10;
   localparam logic [7:0] IND_ERR   = 8'h11;   // Mismatch count, read only

   // -----------------------------------------------------------------
   // Patterns, depths and clocking
   // -----------------------------------------------------------------
   localparam logic [3:0] PAT_FIRST  = 4'h1;
   localparam logic [3:0] PAT_LAST   = 4'he;
   localparam logic [8:0] LVL_24     = 9'h100;
   localparam logic [8:0] LVL_18     = 9'h040;
   localparam logic [23:0] MSK_18    = 24'hfcfcfc;
   localparam int         DIV_DEF    = 2;   // Internal pixel clock divide
endpackage

// >>> design/vpg_ind_regs.sv
// Indirectly mapped register memory of the pattern generator
`timescale 1ns/1ps
module vpg_ind_regs #(
   parameter int DEPTH = vpg_pkg::IND_DEPTH
) (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               we,
   input  wire logic [7:0]         addr,
   input  wire logic [7:0]         wdata,
   input  wire logic [7:0]         err_cnt,
   output logic      [DEPTH*8-1:0] words,
   output logic      [7:0]         rdata
);
   import vpg_pkg::*;
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][7:0] mem;
      logic [7:0]            rdata;
   } vpg_ind_s;

   vpg_ind_s s_r;
   vpg_ind_s s_nxt;

   // Write port and registered read of the addressed word
   always_comb begin
      s_nxt = s_r;
      if (we && addr < DEPTH && addr != IND_ERR) begin
         s_nxt.mem[addr[AW-1:0]] = wdata;
      end
      if (addr == IND_ERR) begin
         s_nxt.rdata = err_cnt;
      end else if (addr < DEPTH) begin
         s_nxt.rdata = s_nxt.mem[addr[AW-1:0]];
      end else begin
         s_nxt.rdata = 8'h00;
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign words = s_r.mem;
   assign rdata = s_r.rdata;
endmodule

// >>> design/vpg_top.sv
// Video pattern generator with indirect registers and self-test checker
// Behaviour
// - Depth bit set gives 64 levels and six upper bits; clear gives 256 levels
// - With own timing, clock source bit picks external pixel clock or divided clock
// - Clock source bit is ignored while external timing is selected
// - Timing select 1 builds frame timing from programmed sizes, widths and porches
// - Timing select 0 follows external pixel clock, enable and syncs
// - Inversion bit set outputs bitwise inverse colour, clear passes colour
// - Auto-scroll counts frames and advances pattern when count reaches frame time
// - Without auto-scroll the selected pattern stays indefinitely
// - Indirect address register selects which indirect register data port reaches
// - Writing indirect data stores the byte into the addressed indirect register
// - Reading indirect data returns the addressed indirect register contents
// - Self-test enable compares received pixels against local pattern, counts mismatches
// - Self-test error flag in bit 7 is set while mismatch count is non-zero
// - Generator outputs only while enabled; clearing enable stops generation unless self-test is on
// - Auto-scroll ignores the fixed pattern selection field
`timescale 1ns/1ps
module vpg_top #(
   parameter logic [7:0] DIV = 8'(vpg_pkg::DIV_DEF)
) (
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   input  wire logic [vpg_pkg::PADDR_W-1:0]  paddr,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire logic                         ext_pclk,
   input  wire logic                         ext_de,
   input  wire logic                         ext_hs,
   input  wire logic                         ext_vs,
   input  wire logic [23:0]                  rx_rgb,
   output logic      [23:0]                  vid_rgb,
   output logic                              vid_de,
   output logic                              vid_hs,
   output logic                              vid_vs,
   output logic                              bist_err
);
   import vpg_pkg::*;

   typedef struct packed {
      logic [2:0]  pclk_q;
      logic [1:0]  de_q;
      logic [1:0]  hs_q;
      logic [1:0]  vs_q;
      logic [7:0]  divc;
      logic [11:0] h;
      logic [11:0] v;
      logic [11:0] hacc;
      logic [11:0] vacc;
      logic [7:0]  hl;
      logic [7:0]  vl;
      logic        de_p;
      logic        vs_p;
      logic [7:0]  fcnt;
      logic [3:0]  spat;
      logic [7:0]  err;
      logic        bist_p;
      logic [7:0]  ctl;
      logic [7:0]  cfg;
      logic [7:0]  ia;
      logic [7:0]  dbg;
      logic [23:0] rgb;
      logic        de;
      logic        hs;
      logic        vs;
      logic        berr;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } vpg_state_s;

   vpg_state_s s_r;
   vpg_state_s s_nxt;

   logic [IND_DEPTH*8-1:0] words;
   logic [7:0]             ind_rdata;
   logic                   ind_we;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [7:0] wd(input logic [IND_DEPTH*8-1:0] w,
                                     input logic [7:0] a);
      return w[a*8 +: 8];
   endfunction

   // One scaling step: spread the levels evenly over the active span
   function automatic logic [19:0] step(input logic [11:0] acc,
                                        input logic [7:0] lvl,
                                        input logic [11:0] span,
                                        input logic [8:0] lvls);
      logic [12:0] sum;
      logic [7:0]  l;
      sum = {1'b0, acc} + {4'h0, lvls};
      l   = lvl;
      if (sum >= {1'b0, span}) begin
         sum = sum - {1'b0, span};
         if ({1'b0, l} != lvls - 9'h001) begin
            l = l + 8'h01;
         end
      end
      return {sum[11:0], l};
   endfunction

   // -----------------------------------------------------------------
   // Decoded configuration
   // -----------------------------------------------------------------
   logic        en, asc, inv, tsel, extc, d18, bist;
   logic [3:0]  sel, cur;
   logic [11:0] toth, totv, acth, actv, hst, vst;
   logic [7:0]  scfg, ft;
   logic [8:0]  lvls;

   always_comb begin
      en   = s_r.ctl[CTL_EN];
      sel  = s_r.ctl[CTL_SEL +: 4];
      asc  = s_r.cfg[CFG_ASCRL];
      inv  = s_r.cfg[CFG_INV];
      tsel = s_r.cfg[CFG_TSEL];
      extc = s_r.cfg[CFG_EXTCLK];
      d18  = s_r.cfg[CFG_18B];
      bist = s_r.dbg[DBG_BIST];
      lvls = d18 ? LVL_18 : LVL_24;
      cur  = asc ? s_r.spat : sel;
      // High nibble sits in the byte after the low byte of each size pair
      toth = {words[IND_TOTH*8+8 +: 4], wd(words, IND_TOTH)};
      totv = {words[IND_TOTV*8+8 +: 4], wd(words, IND_TOTV)};
      acth = {words[IND_ACTH*8+8 +: 4], wd(words, IND_ACTH)};
      actv = {words[IND_ACTV*8+8 +: 4], wd(words, IND_ACTV)};
      hst  = {4'h0, wd(words, IND_HSW)} + {4'h0, wd(words, IND_HBP)};
      vst  = {4'h0, wd(words, IND_VSW)} + {4'h0, wd(words, IND_VBP)};
      scfg = wd(words, IND_SYNC);
      ft   = wd(words, IND_FT);
   end

   // -----------------------------------------------------------------
   // Pixel rate and frame timing
   // -----------------------------------------------------------------
   logic pclk_rise, div_tick, pix_en, i_de, t_de, t_hs, t_vs;

   always_comb begin
      pclk_rise = s_r.pclk_q[1] & ~s_r.pclk_q[2];
      div_tick  = (s_r.divc == DIV - 8'h01);
      pix_en    = tsel ? (extc ? pclk_rise : div_tick) : pclk_rise;
      i_de = (s_r.h >= hst) && (s_r.h < hst + acth) &&
             (s_r.v >= vst) && (s_r.v < vst + actv);
      t_de = tsel ? i_de : s_r.de_q[1];
      t_hs = tsel ? (s_r.h < {4'h0, wd(words, IND_HSW)}) : s_r.hs_q[1];
      t_vs = tsel ? (s_r.v < {4'h0, wd(words, IND_VSW)}) : s_r.vs_q[1];
   end

   // -----------------------------------------------------------------
   // Pattern colour for the current pixel
   // -----------------------------------------------------------------
   logic [7:0]  hlv, vlv;
   logic [23:0] raw, col;

   always_comb begin
      hlv = s_r.hl;
      vlv = s_r.vl;
      unique case (cur)
         4'h1:    raw = 24'hffffff;
         4'h2:    raw = 24'h000000;
         4'h3:    raw = 24'hff0000;
         4'h4:    raw = 24'h00ff00;
         4'h5:    raw = 24'h0000ff;
         4'h6:    raw = {hlv, hlv, hlv};
         4'h7:    raw = {hlv, 16'h0000};
         4'h8:    raw = {8'h00, hlv, 8'h00};
         4'h9:    raw = {16'h0000, hlv};
         4'ha:    raw = {vlv, vlv, vlv};
         4'hb:    raw = {vlv, 16'h0000};
         4'hc:    raw = {8'h00, vlv, 8'h00};
         4'hd:    raw = {16'h0000, vlv};
         4'he:    raw = {wd(words, IND_RED), wd(words, IND_GRN), wd(words, IND_BLU)};
         default: raw = 24'h000000;
      endcase
      col = raw ^ {24{inv}};
      if (d18) begin
         col = col & MSK_18;
      end
   end

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   logic       setup, acc, hit;
   logic [7:0] idx, rd;

   always_comb begin
      setup = psel & ~penable;
      acc   = psel & penable & s_r.pready;
      idx   = paddr[9:2];
      hit   = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
              (idx >= IX_CTL) && (idx <= IX_RES);
      unique case (idx)
         IX_CTL:  rd = s_r.ctl;
         IX_CFG:  rd = s_r.cfg & CFG_MSK;
         IX_IA:   rd = s_r.ia;
         IX_ID:   rd = ind_rdata;
         IX_DBG:  rd = s_r.dbg;
         IX_RES:  rd = {s_r.err != 8'h00, 7'h00};
         default: rd = 8'h00;
      endcase
      ind_we = acc & pwrite & hit & (idx == IX_ID);
   end

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   logic [19:0] hs_step, vs_step;

   always_comb begin
      s_nxt   = s_r;
      hs_step = step(s_r.hacc, s_r.hl, acth, lvls);
      vs_step = step(s_r.vacc, s_r.vl, actv, lvls);
      // Pin synchronisers
      s_nxt.pclk_q = {s_r.pclk_q[1:0], ext_pclk};
      s_nxt.de_q   = {s_r.de_q[0], ext_de};
      s_nxt.hs_q   = {s_r.hs_q[0], ext_hs};
      s_nxt.vs_q   = {s_r.vs_q[0], ext_vs};
      s_nxt.divc   = div_tick ? 8'h00 : s_r.divc + 8'h01;
      // Generator runs while enabled or while the checker needs it
      if (pix_en && (en || bist)) begin
         if (tsel) begin
            if (s_r.h + 12'h001 >= toth) begin
               s_nxt.h = 12'h000;
               s_nxt.v = (s_r.v + 12'h001 >= totv) ? 12'h000 : s_r.v + 12'h001;
            end else begin
               s_nxt.h = s_r.h + 12'h001;
            end
         end
         s_nxt.de_p = t_de;
         s_nxt.vs_p = t_vs;
         if (t_de) begin
            {s_nxt.hacc, s_nxt.hl} = hs_step;
         end else begin
            s_nxt.hacc = 12'h000;
            s_nxt.hl   = 8'h00;
         end
         if (s_r.de_p && !t_de) begin
            {s_nxt.vacc, s_nxt.vl} = vs_step;
         end
         // New frame: restart vertical scale and count frames
         if (t_vs && !s_r.vs_p) begin
            s_nxt.vacc = 12'h000;
            s_nxt.vl   = 8'h00;
            if (asc) begin
               if (s_r.fcnt + 8'h01 >= ft) begin
                  s_nxt.fcnt = 8'h00;
                  s_nxt.spat = (s_r.spat >= PAT_LAST) ? PAT_FIRST : s_r.spat + 4'h1;
               end else begin
                  s_nxt.fcnt = s_r.fcnt + 8'h01;
               end
            end
         end
         s_nxt.de  = t_de & en;
         s_nxt.rgb = (t_de && en) ? col : 24'h000000;
         s_nxt.hs  = (t_hs & en) ^ scfg[0];
         s_nxt.vs  = (t_vs & en) ^ scfg[1];
      end
      if (!asc) begin
         s_nxt.fcnt = 8'h00;
         s_nxt.spat = sel;
      end
      if (!en) begin
         s_nxt.de  = 1'b0;
         s_nxt.rgb = 24'h000000;
         s_nxt.hs  = scfg[0];
         s_nxt.vs  = scfg[1];
      end
      // Self-test: count active-pixel mismatches, cleared on enable
      s_nxt.bist_p = bist;
      if (bist && !s_r.bist_p) begin
         s_nxt.err = 8'h00;
      end else if (pix_en && bist && t_de && rx_rgb != col && s_r.err != 8'hff) begin
         s_nxt.err = s_r.err + 8'h01;
      end
      s_nxt.berr = (s_nxt.err != 8'h00);
      // Bus slave: answer in the first access cycle
      s_nxt.pready  = setup;
      s_nxt.pslverr = setup & ~hit;
      if (setup && !pwrite) begin
         s_nxt.prdata = {24'h000000, hit ? rd : 8'h00};
      end
      if (acc && pwrite && hit) begin
         unique case (idx)
            IX_CTL:  s_nxt.ctl = pwdata[7:0];
            IX_CFG:  s_nxt.cfg = pwdata[7:0] & CFG_MSK;
            IX_IA:   s_nxt.ia  = pwdata[7:0];
            IX_DBG:  s_nxt.dbg = pwdata[7:0];
            default: s_nxt.ia  = s_r.ia;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r      <= '0;
         s_r.ctl  <= CTL_RST;
         s_r.cfg  <= CFG_RST;
         s_r.ia   <= IA_RST;
         s_r.dbg  <= DBG_RST;
         s_r.spat <= PAT_FIRST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Indirect registers addressed by the indirect address register
   vpg_ind_regs #(
      .DEPTH   (IND_DEPTH)
   ) u_ind (
      .clk     (clk),
      .rst_n   (rst_n),
      .we      (ind_we),
      .addr    (s_r.ia),
      .wdata   (pwdata[7:0]),
      .err_cnt (s_r.err),
      .words   (words),
      .rdata   (ind_rdata)
   );

   assign prdata   = s_r.prdata;
   assign pready   = s_r.pready;
   assign pslverr  = s_r.pslverr;
   assign vid_rgb  = s_r.rgb;
   assign vid_de   = s_r.de;
   assign vid_hs   = s_r.hs;
   assign vid_vs   = s_r.vs;
   assign bist_err = s_r.berr;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_depth_low_bits: assert property ($past(d18) && $past(pix_en) |->
      (vid_rgb & ~MSK_18) == 24'h000000) else $error("18-bit low bits set");
   a_divided_clock: assert property (tsel && !extc && pix_en |-> div_tick)
      else $error("internal timing not on divided clock");
   a_ext_timing_clk: assert property (!tsel && pix_en |-> pclk_rise)
      else $error("external timing not on pixel clock");
   a_invert_white: assert property (pix_en && en && t_de && cur == 4'h1 |=>
      vid_rgb == ($past(inv) ? 24'h000000 : $past(d18) ? MSK_18 : 24'hffffff))
      else $error("white pattern colour wrong");
   a_scroll_wrap: assert property (pix_en && en && asc && t_vs && !s_r.vs_p &&
      s_r.fcnt + 8'h01 >= ft && asc |=> s_r.fcnt == 8'h00 &&
      s_r.spat != $past(s_r.spat)) else $error("scroll did not advance");
   a_ind_write: assert property (ind_we && s_r.ia != IND_ERR && s_r.ia < IND_DEPTH
      |=> ##1 ind_rdata == $past(pwdata[7:0], 2)) else $error("indirect write lost");
   a_err_flag: assert property (bist_err == (s_r.err != 8'h00))
      else $error("error flag disagrees with count");
   a_disabled_quiet: assert property (!en ##1 !en |-> !vid_de && vid_rgb == 24'h0)
      else $error("output while disabled");
   a_blank_no_err: assert property (!t_de && !(bist && !s_r.bist_p) |=>
      $stable(s_r.err)) else $error("blanking changed count");
   a_apb_answer: assert property (setup |=> pready && pslverr == !$past(hit))
      else $error("bus answer missing");
endmodule

// >>> verification/vpg_video_src.sv
// Upstream video source model with its own pixel clock and frame timing
`timescale 1ns/1ps
module vpg_video_src (
   input  wire logic        clk,
   input  wire logic        run,
   input  wire logic        corrupt,
   input  wire logic [23:0] colour,
   output logic             ext_pclk,
   output logic             ext_de,
   output logic             ext_hs,
   output logic             ext_vs,
   output logic [23:0]      rx_rgb
);
   int ph  = 0;
   int h   = 0;
   int v   = 0;
   int cnt = 0;

   // -----------------------------------------------------------------
   // Pixel position; advances as the pixel clock falls
   // -----------------------------------------------------------------
   always @(posedge clk) begin
      cnt <= cnt + 1;
      if (!run) begin
         ph <= 0;
         h  <= 0;
         v  <= 0;
      end else begin
         ph <= (ph + 1) % 4;
         if (ph == 3) begin
            h <= (h + 1) % 10;
            if (h == 9) begin
               v <= (v + 1) % 6;
            end
         end
      end
   end

   // Clock stands low outside frames; 10 x 6 frame, 4 x 2 active area
   assign ext_pclk = run && ph >= 2;
   assign ext_hs   = run && h < 1;
   assign ext_vs   = run && v < 1;
   assign ext_de   = run && h >= 3 && h < 7 && v >= 2 && v < 4;
   // Same colour as the local generator; first blank row and faults send the inverse
   assign rx_rgb   = !run ? {3{cnt[7:0]}} : (corrupt || v == 0) ? ~colour : colour;
endmodule

// >>> verification/video_pattern_generator_bist_tb.sv
// Self-checking bench of the video pattern generator
`timescale 1ns/1ps
module video_pattern_generator_bist_tb;
   import vpg_pkg::*;
   logic                 clk, rst_n, psel, penable, pwrite, pready, pslverr, er, skip_rgb;
   logic [PADDR_W-1:0]   paddr;
   logic [31:0]          pwdata, prdata, rd;
   logic                 ext_pclk, ext_de, ext_hs, ext_vs, vid_de, vid_hs, vid_vs, bist_err;
   logic                 run, corrupt;
   logic [23:0]          rx_rgb, vid_rgb, colour;
   logic [7:0]           ind_m [IND_DEPTH];
   logic [7:0]           rst_v [6] = '{CTL_RST, CFG_RST, IA_RST, 8'h00, DBG_RST, 8'h00};
   logic [7:0]           tim [13] = '{8, 0, 6, 0, 4, 0, 2, 0, 1, 1, 1, 1, 0};
   int                   n_mismatch = 0;
   int                   n_tests = 0;
   int                   n_chg;

   vpg_top #(.DIV(8'd2)) vpg_top_inst (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_pclk(ext_pclk), .ext_de(ext_de), .ext_hs(ext_hs),
      .ext_vs(ext_vs), .rx_rgb(rx_rgb), .vid_rgb(vid_rgb), .vid_de(vid_de),
      .vid_hs(vid_hs), .vid_vs(vid_vs), .bist_err(bist_err));
   vpg_video_src vpg_video_src_inst (.clk(clk), .run(run), .corrupt(corrupt),
      .colour(colour), .ext_pclk(ext_pclk), .ext_de(ext_de), .ext_hs(ext_hs),
      .ext_vs(ext_vs), .rx_rgb(rx_rgb));

   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // -----------------------------------------------------------------
   // Comparison, verdict and bus tasks
   // -----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] d);
      int i;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= {2'b00, ix, 2'b00};
      pwdata  <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (i >= 20) begin
         n_mismatch++;
         stop_test();
      end
   endtask

   task automatic rdchk(input logic [7:0] ix, input logic [7:0] exp);
      apb(1'b0, ix, 8'h00);
      check(rd, {24'h0, exp});
   endtask

   // Indirect access always loads the address first
   task automatic iwr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, IX_IA, a);
      apb(1'b1, IX_ID, d);
      if (a < IND_DEPTH && a != IND_ERR) ind_m[a] = d;
   endtask

   task automatic ird(input logic [7:0] a);
      apb(1'b1, IX_IA, a);
      apb(1'b0, IX_ID, 8'h00);
   endtask

   // Counts active, sync cycles over a window after settling; checks colour
   task automatic watch(input int n, input logic [23:0] e, input int ede, ehs, evs);
      int          cde, chs, cvs;
      logic [23:0] last;
      cde = 0;
      chs = 0;
      cvs = 0;
      n_chg = 0;
      last = e;
      repeat (500) @(posedge clk);
      repeat (n) begin
         @(negedge clk);
         if (vid_de === 1'b1) begin
            cde++;
            if (vid_rgb !== last) n_chg++;
            last = vid_rgb;
            if (!skip_rgb) check({8'h0, vid_rgb}, {8'h0, e});
         end
         chs += (vid_hs === 1'b1);
         cvs += (vid_vs === 1'b1);
      end
      check(cde, ede);
      check(chs, ehs);
      check(cvs, evs);
   endtask

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      run = 1'b0;
      corrupt = 1'b0;
      colour = 24'hffffff;
      skip_rgb = 1'b0;
      void'($urandom(32'h5263ce62));
      foreach (ind_m[i]) ind_m[i] = 8'h00;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int k = 0; k < 6; k++) rdchk(IX_CTL + 8'(k), rst_v[k]);
      apb(1'b0, 8'h70, 8'h00);
      check(er, 1'b1);
      apb(1'b1, IX_RES, 8'hff);
      rdchk(IX_RES, 8'h00);
      apb(1'b1, IX_CFG, 8'hff);
      rdchk(IX_CFG, CFG_MSK);
      // Random indirect contents read back in reverse order
      for (int a = 0; a < 16; a++) iwr(8'(a), 8'($urandom));
      for (int a = 15; a >= 0; a--) begin
         ird(8'(a));
         check(rd, {24'h0, ind_m[a]});
      end
      iwr(IND_ERR, 8'h5a);
      ird(IND_ERR);
      check(rd, 32'h0);
      // Small frame: 8 x 6 total, 4 x 2 active, unit syncs and porches
      for (int a = 0; a < 13; a++) iwr(8'(a), tim[a]);
      iwr(IND_FT, 8'h01);
      iwr(IND_RED, 8'h13);
      iwr(IND_GRN, 8'h57);
      iwr(IND_BLU, 8'ha9);
      apb(1'b1, IX_CFG, 8'h04);
      apb(1'b1, IX_CTL, 8'h11);
      watch(96, 24'hffffff, 16, 12, 16);
      apb(1'b1, IX_CFG, 8'h06);
      watch(96, 24'h000000, 16, 12, 16);
      apb(1'b1, IX_CFG, 8'h04);
      apb(1'b1, IX_CTL, 8'h31);
      watch(288, 24'hff0000, 48, 36, 48);
      apb(1'b1, IX_CTL, 8'he1);
      apb(1'b1, IX_CFG, 8'h14);
      watch(96, 24'h1357a9 & MSK_18, 16, 12, 16);
      apb(1'b1, IX_CFG, 8'h16);
      watch(96, ~24'h1357a9 & MSK_18, 16, 12, 16);
      run <= 1'b1;
      apb(1'b1, IX_CFG, 8'h0c);
      watch(192, 24'h1357a9, 32, 24, 32);
      apb(1'b1, IX_CFG, 8'h05);
      skip_rgb = 1'b1;
      watch(288, 24'h000000, 48, 36, 48);
      check(n_chg != 0, 1'b1);
      skip_rgb = 1'b0;
      apb(1'b1, IX_CFG, 8'h08);
      apb(1'b1, IX_CTL, 8'h11);
      watch(240, 24'hffffff, 32, 24, 40);
      apb(1'b1, IX_CTL, 8'h10);
      watch(240, 24'h000000, 0, 0, 0);
      // Self-test with a matching source, then with a faulty one
      apb(1'b1, IX_CTL, 8'h11);
      apb(1'b1, IX_DBG, 8'h08);
      watch(480, 24'hffffff, 64, 48, 80);
      check(bist_err, 1'b0);
      rdchk(IX_RES, 8'h00);
      apb(1'b1, IX_DBG, 8'h00);
      corrupt <= 1'b1;
      apb(1'b1, IX_DBG, 8'h08);
      watch(240, 24'hffffff, 32, 24, 40);
      check(bist_err, 1'b1);
      rdchk(IX_RES, 8'h80);
      ird(IND_ERR);
      check(rd[7:0] != 8'h00, 1'b1);
      stop_test();
   end
endmodule
